// ### hdl/reset_pin_and_mode_select.sv
// reset pin sequencer, reset cause capture, mode select and debug pin
// Behaviour
// - any reset drives pin low 34 ticks
// - release, wait 38 ticks, resample pin
// - internal reset expects high resample
// - record reset cause for software
// - external low on pin forces reset
// - run from self-clock during reset
// - software selects self-clock stop recovery
// - range bit picks oscillator range
// - crystal output pin usable as port
// - mode input in reset, debug after
// - mode pin high gives normal mode
// - shared port bit is output only
// - debug bit lasts sixteen cycles
// - actively driven high speedup pulses
`timescale 1ns/1ps
`default_nettype none
module reset_pin_and_mode_select #(
    parameter int DRIVE_TICKS = rst_seq_pkg::DRIVE_TICKS,
    parameter int SAMPLE_TICKS = rst_seq_pkg::SAMPLE_TICKS,
    parameter int SELF_DIV = rst_seq_pkg::SELF_DIV
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // register bus
    input wire rst_seq_pkg::ahb_req_t ahb_req_in,
    output var rst_seq_pkg::ahb_rsp_t ahb_rsp_out,
    // internal reset sources
    input wire logic lvd_reset_in,
    input wire logic watchdog_reset_in,
    input wire logic illegal_opcode_in,
    input wire logic illegal_addr_in,
    // reset pin
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_out,
    // debug_mode_select_pin
    input wire logic debug_pin_in,
    output logic debug_pin_out,
    output logic debug_pin_oe_out,
    // crystal_output_pin as port
    output logic crystal_output_pin_out,
    output logic crystal_output_pin_oe_out,
    // system controls
    output logic sys_reset_n_out,
    output logic self_clock_sel_out,
    output logic stop_recover_self_out,
    output logic osc_range_high_out,
    output logic active_debug_pin_out
);
    localparam int CW = rst_seq_pkg::CNT_W;
    localparam int DW = rst_seq_pkg::DIV_W;
    localparam logic [CW-1:0] DRIVE_LAST = CW'(DRIVE_TICKS - 1);
    localparam logic [CW-1:0] SAMPLE_LAST = CW'(SAMPLE_TICKS - 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(SELF_DIV - 1);
    // entry cycle counts as the first of the tick period
    localparam logic [DW-1:0] DIV_START = DW'(1);
    localparam int DRIVE_CYC = DRIVE_TICKS * SELF_DIV;
    localparam int WAIT_CYC = SAMPLE_TICKS * SELF_DIV;

    // refuse counts the counters cannot hold
    if (DRIVE_TICKS < 1 || DRIVE_TICKS > 2 ** CW) begin : g_bad_drive
        $error("DRIVE_TICKS out of range");
    end
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 2 ** CW) begin : g_bad_sample
        $error("SAMPLE_TICKS out of range");
    end
    if (SELF_DIV < 9 || SELF_DIV > 2 ** DW) begin : g_bad_div
        $error("SELF_DIV out of range");
    end

    rst_seq_pkg::core_state_t st;
    rst_seq_pkg::core_state_t next_st;

    logic reset_level;
    logic mode_level;
    logic [rst_seq_pkg::CAUSE_W-1:0] int_cause;
    logic addr_ok;
    logic in_map;
    logic [31:0] read_word;
    logic dbg_enable;
    logic dbg_load;
    logic dbg_out;
    logic dbg_oe;
    logic [7:0] dbg_rx;
    logic [2:0] dbg_nbits;
    logic running;

    // both pins pass the three-flop filter before use
    pin_sync3 #(
        .W(2),
        .RESET_VAL(2'h3)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .raw_in({debug_pin_in, reset_pin_in}),
        .level_out({mode_level, reset_level})
    );

    assign running = (st.seq == rst_seq_pkg::SEQ_RUN);
    assign dbg_enable = running && !st.port[rst_seq_pkg::PORT_GPIO_SEL];
    assign dbg_load = st.dph_wr && running && (st.dph_addr == rst_seq_pkg::DBG_DATA_ADDR);

    debug_bit_cell u_dbg (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .enable_in(dbg_enable),
        .load_in(dbg_load),
        .load_byte_in(ahb_req_in.hwdata[7:0]),
        .pin_in(mode_level),
        .pin_out(dbg_out),
        .pin_oe_out(dbg_oe),
        .rx_byte_out(dbg_rx),
        .nbits_out(dbg_nbits)
    );

    always_comb begin
        int_cause = '0;
        if (lvd_reset_in) begin
            int_cause[rst_seq_pkg::CAUSE_LVD] = 1'b1;
        end else if (watchdog_reset_in) begin
            int_cause[rst_seq_pkg::CAUSE_WDOG] = 1'b1;
        end else if (illegal_opcode_in) begin
            int_cause[rst_seq_pkg::CAUSE_ILOP] = 1'b1;
        end else if (illegal_addr_in) begin
            int_cause[rst_seq_pkg::CAUSE_ILAD] = 1'b1;
        end
    end

    // bus address phase decode; unmapped words read zero
    assign addr_ok = ahb_req_in.hsel && ahb_req_in.hready &&
                     ahb_req_in.htrans[rst_seq_pkg::HTRANS_ACTIVE_BIT];
    assign in_map = (ahb_req_in.haddr[31:8] == 24'h000000);

    // read mux, sampled in the address phase
    always_comb begin
        read_word = 32'h00000000;
        case (ahb_req_in.haddr[7:0])
            rst_seq_pkg::CAUSE_ADDR: read_word[rst_seq_pkg::CAUSE_W-1:0] = st.cause;
            rst_seq_pkg::CGC1_ADDR: read_word[rst_seq_pkg::CGC_W-1:0] = st.cgc;
            rst_seq_pkg::PORT_ADDR: read_word[rst_seq_pkg::PORT_W-1:0] = st.port;
            rst_seq_pkg::STATUS_ADDR: begin
                read_word[rst_seq_pkg::ST_DEBUG_PIN] = st.debug_pin;
                read_word[rst_seq_pkg::ST_BUSY] = !running;
                read_word[rst_seq_pkg::ST_PIN_HELD] = st.pin_held;
                read_word[rst_seq_pkg::ST_NBITS_LSB +: 3] = dbg_nbits;
            end
            rst_seq_pkg::DBG_DATA_ADDR: read_word[7:0] = dbg_rx;
            default: read_word = 32'h00000000;
        endcase
        if (!in_map) begin
            read_word = 32'h00000000;
        end
    end

    // next state: bus, self-clock tick and reset sequence
    always_comb begin
        next_st = st;
        next_st.tick = (st.div == DIV_LAST);
        next_st.div = next_st.tick ? '0 : DW'(st.div + 1'b1);
        next_st.dph_wr = addr_ok && ahb_req_in.hwrite && in_map;
        next_st.dph_addr = ahb_req_in.haddr[7:0];
        if (addr_ok && !ahb_req_in.hwrite) begin
            next_st.rdata = read_word;
        end
        // data phase writes, ignored during reset
        if (st.dph_wr && running) begin
            case (st.dph_addr)
                rst_seq_pkg::CGC1_ADDR: next_st.cgc = ahb_req_in.hwdata[rst_seq_pkg::CGC_W-1:0];
                rst_seq_pkg::PORT_ADDR: next_st.port = ahb_req_in.hwdata[rst_seq_pkg::PORT_W-1:0];
                default: ;
            endcase
        end
        case (st.seq)
            rst_seq_pkg::SEQ_RUN: begin
                if (int_cause != '0 || !reset_level) begin
                    next_st.seq = rst_seq_pkg::SEQ_DRIVE;
                    next_st.cnt = '0;
                    next_st.div = DIV_START;
                    next_st.tick = 1'b0;
                    next_st.pin_held = 1'b0;
                    next_st.cgc = rst_seq_pkg::CGC_RESET;
                    next_st.port = rst_seq_pkg::PORT_RESET;
                    next_st.cause = '0;
                    if (int_cause != '0) begin
                        next_st.cause = int_cause;
                    end else begin
                        next_st.cause[rst_seq_pkg::CAUSE_PIN] = 1'b1;
                    end
                end
            end
            rst_seq_pkg::SEQ_DRIVE: begin
                if (st.tick) begin
                    next_st.cnt = st.cnt + 1'b1;
                    if (st.cnt == DRIVE_LAST) begin
                        next_st.seq = rst_seq_pkg::SEQ_WAIT;
                        next_st.cnt = '0;
                    end
                end
            end
            rst_seq_pkg::SEQ_WAIT: begin
                if (st.tick) begin
                    next_st.cnt = st.cnt + 1'b1;
                    if (st.cnt == SAMPLE_LAST) begin
                        next_st.cnt = '0;
                        if (reset_level) begin
                            next_st.seq = rst_seq_pkg::SEQ_RUN;
                            next_st.debug_pin = !mode_level;
                        end else begin
                            // outside party still holds reset
                            next_st.seq = rst_seq_pkg::SEQ_HOLD;
                            next_st.pin_held = 1'b1;
                            next_st.cause[rst_seq_pkg::CAUSE_PIN] = 1'b1;
                        end
                    end
                end
            end
            rst_seq_pkg::SEQ_HOLD: begin
                if (reset_level) begin
                    next_st.seq = rst_seq_pkg::SEQ_RUN;
                    next_st.debug_pin = !mode_level;
                end
            end
            default: next_st.seq = rst_seq_pkg::SEQ_DRIVE;
        endcase
    end

    // power-on starts the same drive sequence
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '{seq: rst_seq_pkg::SEQ_DRIVE, cnt: '0, div: DIV_START, tick: 1'b0,
                    cause: rst_seq_pkg::CAUSE_RESET, pin_held: 1'b0, debug_pin: 1'b0,
                    cgc: rst_seq_pkg::CGC_RESET, port: rst_seq_pkg::PORT_RESET,
                    dph_wr: 1'b0, dph_addr: 8'h00, rdata: 32'h00000000};
        end else begin
            st <= next_st;
        end
    end

    // bus answer: zero wait, always okay
    assign ahb_rsp_out.hrdata = st.rdata;
    assign ahb_rsp_out.hreadyout = 1'b1;
    assign ahb_rsp_out.hresp = 1'b0;

    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_out = (st.seq == rst_seq_pkg::SEQ_DRIVE);

    always_comb begin
        debug_pin_out = 1'b0;
        debug_pin_oe_out = 1'b0;
        if (running && st.port[rst_seq_pkg::PORT_GPIO_SEL]) begin
            debug_pin_out = st.port[rst_seq_pkg::PORT_DATA];
            debug_pin_oe_out = 1'b1;
        end else if (dbg_enable) begin
            debug_pin_out = dbg_out;
            debug_pin_oe_out = dbg_oe;
        end
    end

    // crystal output pin as port output
    assign crystal_output_pin_oe_out = st.cgc[rst_seq_pkg::CGC_CRYSTAL_OUTPUT_PIN_GPIO];
    assign crystal_output_pin_out = st.cgc[rst_seq_pkg::CGC_CRYSTAL_OUTPUT_PIN_GPIO] &&
                                    st.cgc[rst_seq_pkg::CGC_CRYSTAL_OUTPUT_PIN_DATA];
    assign sys_reset_n_out = running;
    assign self_clock_sel_out = !running;
    assign stop_recover_self_out = st.cgc[rst_seq_pkg::CGC_STOP_SELF];
    assign osc_range_high_out = st.cgc[rst_seq_pkg::CGC_RANGE];
    assign active_debug_pin_out = st.debug_pin;

    // cycles spent in the current sequence state, for checks only
    logic [15:0] seq_age;
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            seq_age <= 16'h0001;
        end else if (next_st.seq != st.seq) begin
            seq_age <= 16'h0001;
        end else begin
            seq_age <= seq_age + 16'h0001;
        end
    end

    AST_DRIVE_LOW: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        st.seq == rst_seq_pkg::SEQ_DRIVE |-> reset_pin_oe_out && !reset_pin_out
    ) else $error("reset pin not driven low in drive phase");

    AST_DRIVE_LEN: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        $fell(st.seq == rst_seq_pkg::SEQ_DRIVE) |-> $past(seq_age) == 16'(DRIVE_CYC)
    ) else $error("reset pin low drive has wrong length");

    AST_WAIT_LEN: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        $fell(st.seq == rst_seq_pkg::SEQ_WAIT) |-> $past(seq_age) == 16'(WAIT_CYC)
    ) else $error("resample wait has wrong length");

    AST_WAIT_RELEASE: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        st.seq == rst_seq_pkg::SEQ_WAIT |-> !reset_pin_oe_out
    ) else $error("reset pin driven during wait");

    AST_SAMPLE_HIGH: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        st.seq == rst_seq_pkg::SEQ_WAIT && st.tick && st.cnt == SAMPLE_LAST && reset_level
        |=> sys_reset_n_out && !st.pin_held
    ) else $error("high resample did not release reset");

    AST_CAUSE_PIN: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        running && !reset_level && int_cause == '0
        |=> st.cause == rst_seq_pkg::CAUSE_W'(1 << rst_seq_pkg::CAUSE_PIN)
    ) else $error("pin reset cause not recorded");

    AST_PIN_REQ: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        running && !reset_level |=> st.seq == rst_seq_pkg::SEQ_DRIVE ##1 reset_pin_oe_out
    ) else $error("external low did not start reset");

    AST_SELF_CLK: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !sys_reset_n_out |-> self_clock_sel_out && !stop_recover_self_out
    ) else $error("self-clock not selected in reset");

    AST_PIN_INPUT: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !sys_reset_n_out |-> !debug_pin_oe_out
    ) else $error("mode pin driven during reset");

    AST_MODE: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        $rose(sys_reset_n_out) |-> active_debug_pin_out == !$past(mode_level)
    ) else $error("mode not taken from pin at release");

    AST_GPIO_OUT: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        running && st.port[rst_seq_pkg::PORT_GPIO_SEL]
        |-> debug_pin_oe_out && debug_pin_out == st.port[rst_seq_pkg::PORT_DATA]
    ) else $error("shared port bit not driving");

    AST_TICK: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        st.tick |=> !st.tick [*8]
    ) else $error("self-clock ticks too close");
endmodule // reset_pin_and_mode_select
`default_nettype wire

// ### hdl/rst_seq_pkg.sv
// constants and types for reset pin sequencing and mode select
package rst_seq_pkg;
    // reference clock and internal self-clock rates
    localparam int REF_CLK_HZ = 100_000_000;
    localparam int SELF_CLK_HZ = 8_000_000;
    localparam int SELF_DIV = REF_CLK_HZ / SELF_CLK_HZ;
    localparam int DIV_W = 4;
    localparam int CNT_W = 6;
    // reset pin drive and resample lengths in self-clock ticks
    localparam int DRIVE_TICKS = 34;
    localparam int SAMPLE_TICKS = 38;
    // debug bit timing in reference clock cycles
    localparam int DBG_BIT_CYC = 16;
    localparam int DBG_SAMPLE_CYC = 10;
    localparam int DBG_LOW_CYC = 13;
    localparam int DBG_CNT_W = 4;
    localparam int HTRANS_ACTIVE_BIT = 1;
    // register byte offsets
    localparam logic [7:0] CAUSE_ADDR = 8'h00;
    localparam logic [7:0] CGC1_ADDR = 8'h04;
    localparam logic [7:0] PORT_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0c;
    localparam logic [7:0] DBG_DATA_ADDR = 8'h10;
    // reset_cause_register bits
    localparam int CAUSE_W = 6;
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_LVD = 2;
    localparam int CAUSE_WDOG = 3;
    localparam int CAUSE_ILOP = 4;
    localparam int CAUSE_ILAD = 5;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 6'h01;
    // clock_gen_control_one fields
    localparam int CGC_W = 4;
    localparam int CGC_RANGE = 0;
    localparam int CGC_STOP_SELF = 1;
    localparam int CGC_CRYSTAL_OUTPUT_PIN_GPIO = 2;
    localparam int CGC_CRYSTAL_OUTPUT_PIN_DATA = 3;
    localparam logic [CGC_W-1:0] CGC_RESET = 4'h0;
    // shared port bit control fields
    localparam int PORT_W = 2;
    localparam int PORT_GPIO_SEL = 0;
    localparam int PORT_DATA = 1;
    localparam logic [PORT_W-1:0] PORT_RESET = 2'h0;
    // status fields
    localparam int ST_DEBUG_PIN = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_PIN_HELD = 2;
    localparam int ST_NBITS_LSB = 4;

    typedef enum logic [1:0] {SEQ_DRIVE, SEQ_WAIT, SEQ_HOLD, SEQ_RUN} seq_state_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_rsp_t;

    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } sync_bit_t;

    typedef struct packed {
        logic [DBG_CNT_W-1:0] cyc;
        logic busy;
        logic prev;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [2:0] nbits;
        logic oe;
        logic out;
    } dbg_state_t;

    typedef struct packed {
        seq_state_t seq;
        logic [CNT_W-1:0] cnt;
        logic [DIV_W-1:0] div;
        logic tick;
        logic [CAUSE_W-1:0] cause;
        logic pin_held;
        logic debug_pin;
        logic [CGC_W-1:0] cgc;
        logic [PORT_W-1:0] port;
        logic dph_wr;
        logic [7:0] dph_addr;
        logic [31:0] rdata;
    } core_state_t;
endpackage

// ### hdl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '1
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // pins and filtered levels
    input wire logic [W-1:0] raw_in,
    output logic [W-1:0] level_out
);
    generate
        for (genvar i = 0; i < W; i++) begin : g_bit
            rst_seq_pkg::sync_bit_t st;
            rst_seq_pkg::sync_bit_t next_st;
            // level follows only once stages two and three agree
            always_comb begin
                next_st = st;
                next_st.stage = {st.stage[1:0], raw_in[i]};
                if (st.stage[1] == st.stage[2]) begin
                    next_st.level = st.stage[2];
                end
            end
            // pullup idles high, so reset to the idle level
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    st <= '{stage: {3{RESET_VAL[i]}}, level: RESET_VAL[i]};
                end else begin
                    st <= next_st;
                end
            end
            assign level_out[i] = st.level;
        end
    endgenerate
endmodule // pin_sync3
`default_nettype wire

// ### hdl/debug_bit_cell.sv
// single-wire debug bit engine: one bit per host-started bit time
`timescale 1ns/1ps
`default_nettype none
module debug_bit_cell (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // control from the register side
    input wire logic enable_in,
    input wire logic load_in,
    input wire logic [7:0] load_byte_in,
    // synchronised pin level and pin drive
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    // received data and bit position
    output logic [7:0] rx_byte_out,
    output logic [2:0] nbits_out
);
    localparam int CW = rst_seq_pkg::DBG_CNT_W;
    localparam logic [CW-1:0] LAST = CW'(rst_seq_pkg::DBG_BIT_CYC - 1);
    localparam logic [CW-1:0] SAMPLE = CW'(rst_seq_pkg::DBG_SAMPLE_CYC);
    localparam logic [CW-1:0] LOW_END = CW'(rst_seq_pkg::DBG_LOW_CYC);

    rst_seq_pkg::dbg_state_t st;
    rst_seq_pkg::dbg_state_t next_st;

    // bit timing, sampling and own drive
    always_comb begin
        next_st = st;
        next_st.prev = pin_in;
        if (load_in) begin
            next_st.tx = load_byte_in;
            next_st.nbits = 3'h0;
        end
        if (!enable_in) begin
            next_st.busy = 1'b0;
        end else if (st.busy) begin
            next_st.cyc = st.cyc + 1'b1;
            if (st.cyc == SAMPLE) begin
                next_st.rx = {st.rx[6:0], pin_in};
            end
            if (st.cyc == LAST) begin
                next_st.busy = 1'b0;
                next_st.tx = {st.tx[6:0], st.tx[7]};
                next_st.nbits = st.nbits + 1'b1;
            end
        end else if (st.prev && !pin_in) begin
            // host falling edge opens a bit
            next_st.busy = 1'b1;
            next_st.cyc = '0;
        end
        next_st.oe = next_st.busy && !st.tx[7] && (next_st.cyc <= LOW_END);
        next_st.out = (next_st.cyc == LOW_END);
    end

    // registered state
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '{cyc: '0, busy: 1'b0, prev: 1'b1, tx: 8'hff, rx: 8'h00,
                    nbits: 3'h0, oe: 1'b0, out: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign pin_out = st.out;
    assign pin_oe_out = st.oe;
    assign rx_byte_out = st.rx;
    assign nbits_out = st.nbits;

    AST_BIT_LEN: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in || !enable_in)
        $rose(st.busy) |-> st.busy [*8] ##1 st.busy [*8] ##1 !st.busy
    ) else $error("debug bit time not sixteen cycles");

    AST_SPEEDUP: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in || !enable_in)
        (st.oe && !st.out) ##1 !(st.oe && !st.out) && st.busy |-> st.oe && st.out
    ) else $error("low drive not ended by speedup pulse");
endmodule // debug_bit_cell
`default_nettype wire

// ### dv/debug_host_model.sv
// reset switch and debug host on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
    // pin drive from the device
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_out,
    input wire logic debug_pin_out,
    input wire logic debug_pin_oe_out,
    // host actions
    input wire logic pull_reset_in,
    input wire logic hold_mode_low_in,
    // resolved pin levels, both with pullups
    output logic reset_level_out,
    output logic debug_level_out
);
    assign reset_level_out = reset_pin_oe_out ? reset_pin_out : !pull_reset_in;
    assign debug_level_out = debug_pin_oe_out ? debug_pin_out : !hold_mode_low_in;
endmodule // debug_host_model
`default_nettype wire

// ### dv/reset_pin_and_mode_select_test.sv
// self-checking bench for reset sequencing, cause and mode select
`timescale 1ns/1ps
`default_nettype none
module reset_pin_and_mode_select_test;
    localparam int DV = 9;
    logic ref_clk_in = 1'b0, nrst_in = 1'b0, lvd = 1'b0, wdog = 1'b0, pull = 1'b0, mlow = 1'b0;
    logic rst_lvl, dbg_lvl, rpo, rpoe, dpo, dpoe, xo, xoe, sysn, selfc, stopr, rng, debug_pin;
    rst_seq_pkg::ahb_req_t m = '0, q;
    rst_seq_pkg::ahb_rsp_t rsp;
    logic [31:0] rd;
    int bad_count = 0, n_checks = 0;
    // hready of the bus is the single slave's hreadyout
    always_comb begin
        q = m;
        q.hready = rsp.hreadyout;
    end
    always #5 ref_clk_in = !ref_clk_in;
    reset_pin_and_mode_select #(.SELF_DIV(DV)) uut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .ahb_req_in(q), .ahb_rsp_out(rsp), .lvd_reset_in(lvd), .watchdog_reset_in(wdog),
        .illegal_opcode_in(1'b0), .illegal_addr_in(1'b0), .reset_pin_in(rst_lvl),
        .reset_pin_out(rpo), .reset_pin_oe_out(rpoe), .debug_pin_in(dbg_lvl), .debug_pin_out(dpo),
        .debug_pin_oe_out(dpoe), .crystal_output_pin_out(xo), .crystal_output_pin_oe_out(xoe),
        .sys_reset_n_out(sysn), .self_clock_sel_out(selfc), .stop_recover_self_out(stopr),
        .osc_range_high_out(rng), .active_debug_pin_out(debug_pin));
    debug_host_model host (.reset_pin_out(rpo), .reset_pin_oe_out(rpoe), .debug_pin_out(dpo),
        .debug_pin_oe_out(dpoe), .pull_reset_in(pull), .hold_mode_low_in(mlow),
        .reset_level_out(rst_lvl), .debug_level_out(dbg_lvl));
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one single word transfer; waits on hready in both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        m.hsel <= 1'b1; m.htrans <= 2'h2; m.hwrite <= w; m.haddr <= {24'h0, a}; m.hsize <= 3'h2;
        do @(posedge ref_clk_in); while (rsp.hreadyout !== 1'b1);
        m.htrans <= 2'h0; m.hwdata <= d;
        do @(posedge ref_clk_in); while (rsp.hreadyout !== 1'b1);
        rd = rsp.hrdata;
    endtask
    // measure one reset sequence from its trigger to run
    task automatic seq(input logic [31:0] cause, input logic mode);
        int n, k;
        n = 0;
        k = 0;
        // look just after the trigger edge so the first drive cycle is counted
        #1;
        while (rpoe !== 1'b1 && k < 20) begin @(posedge ref_clk_in); #1; k++; end
        chk(selfc, 1'b1);
        while (rpoe === 1'b1 && n < 1000) begin @(posedge ref_clk_in); #1; n++; end
        chk(n, 34 * DV);
        k = 0;
        while (sysn !== 1'b1 && k < 1000) begin @(posedge ref_clk_in); #1; k++; end
        chk(k, 38 * DV);
        @(posedge ref_clk_in);
        mlow <= 1'b0;
        ahb(1'b0, rst_seq_pkg::CAUSE_ADDR, 32'h0);
        chk(rd, cause);
        chk(debug_pin, mode);
    endtask
    initial begin
        #100us;
        bad_count++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        seq(32'h1, 1'b0);
        ahb(1'b1, rst_seq_pkg::CGC1_ADDR, 32'hf);
        ahb(1'b1, rst_seq_pkg::PORT_ADDR, 32'h3);
        ahb(1'b0, rst_seq_pkg::CGC1_ADDR, 32'h0);
        chk(rd, 32'hf);
        chk({rng, stopr, xoe, xo}, 4'hf);
        chk({dpoe, dpo}, 2'h3);
        lvd <= 1'b1;
        @(posedge ref_clk_in);
        lvd <= 1'b0;
        seq(32'h4, 1'b0);
        ahb(1'b0, rst_seq_pkg::CGC1_ADDR, 32'h0);
        chk(rd, 32'h0);
        mlow <= 1'b1;
        wdog <= 1'b1;
        @(posedge ref_clk_in);
        wdog <= 1'b0;
        seq(32'h8, 1'b1);
        pull <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        pull <= 1'b0;
        seq(32'h2, 1'b0);
        // short host start pulse, device sends ones so pin reads high at sample
        mlow <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        mlow <= 1'b0;
        repeat (30) @(posedge ref_clk_in);
        ahb(1'b0, rst_seq_pkg::DBG_DATA_ADDR, 32'h0);
        chk(rd, 32'h1);
        ahb(1'b0, rst_seq_pkg::STATUS_ADDR, 32'h0);
        chk(rd, 32'h10);
        test_done();
    end
endmodule // reset_pin_and_mode_select_test
`default_nettype wire
